// *** core/msh_map.svh ***
// Constants of the meter system handshake port: timing, codes, reset values.
// Assumes a single 125 MHz clock shared by both ends.
`ifndef MSH_MAP_SVH
`define MSH_MAP_SVH
`define MSH_CLK_MHZ     125
`define MSH_SETTLE_NS   2000
`define MSH_SETTLE_CYC  ((`MSH_SETTLE_NS * `MSH_CLK_MHZ + 999) / 1000)
`define MSH_TRIG_NS     20000
`define MSH_TRIG_CYC    ((`MSH_TRIG_NS * `MSH_CLK_MHZ) / 1000)
`define MSH_STROBE_CYC  2
`define MSH_ATN_CYC     4
`define MSH_TALK_BASE   8'h40
`define MSH_UNTALK      8'h5F
`define MSH_BUS_IDLE    8'hFF
`define MSH_RANGE_RST   3'h0
`define MSH_FUNC_RST    4'h0
`define MSH_ASC_ZERO    8'h30
`define MSH_ASC_PLUS    8'h2B
`define MSH_ASC_MINUS   8'h2D
`define MSH_NCHAR       3'h7
`endif

// *** core/msh_pkg.sv ***
// Types of the meter system handshake port.
// Assumes nothing beyond a SystemVerilog compiler.
package msh_pkg;
    typedef enum logic [1:0] {DV_IDLE, DV_SETTLE, DV_CONV} msh_dev_st_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_DAV, TX_REL} msh_tx_st_t;
    typedef enum logic [2:0] {H_IDLE, H_PSET, H_PSTB, H_PACK, H_WHI, H_WLO, H_ATN} msh_host_st_t;
endpackage : msh_pkg

// *** core/msh_if.sv ***
// Lines between the meter and its system controller, parallel and serial.
// Assumes both ends run on the same clock; shared data lines idle high.
`timescale 1ns/1ps
`include "msh_map.svh"
interface msh_if;
    logic        trig;
    logic        hold_off_n;
    logic        flag;
    logic [2:0]  prog_range;
    logic [3:0]  prog_func;
    logic        auto_scale_select;
    logic        program_strobe;
    logic        prog_ack;
    logic        seq_launch;
    logic [19:0] rd_digits;
    logic        rd_over;
    logic        rd_pol;
    logic [2:0]  rd_range;
    logic        input_a;
    logic [7:0]  dio_h;
    logic        dio_h_oe;
    logic [7:0]  dio_d;
    logic        dio_d_oe;
    logic [7:0]  dio;
    logic        atn;
    logic        ren;
    logic        dav;
    logic        eoi;
    logic        rfd;
    logic        dac;
    logic        srq;

    // Shared data lines: whoever enables drives, else they float high
    assign dio = dio_d_oe ? dio_d : (dio_h_oe ? dio_h : `MSH_BUS_IDLE);

    modport dev (input trig, hold_off_n, prog_range, prog_func, auto_scale_select,
                 program_strobe, seq_launch, dio, atn, ren, rfd, dac,
                 output flag, prog_ack, rd_digits, rd_over, rd_pol, rd_range, input_a,
                 dio_d, dio_d_oe, dav, eoi, srq);
    modport host (output trig, hold_off_n, prog_range, prog_func, auto_scale_select,
                  program_strobe, seq_launch, dio_h, dio_h_oe, atn, ren, rfd, dac,
                  input flag, prog_ack, rd_digits, rd_over, rd_pol, rd_range, input_a,
                  dio, dav, eoi, srq);
endinterface : msh_if

// *** core/msh_ascii_tx.sv ***
// Serial talker: sends one reading as seven ASCII characters.
// Assumes a listener that raises rfd when ready and dac when it took a byte.
`timescale 1ns/1ps
`include "msh_map.svh"
module msh_ascii_tx
    import msh_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        start_i,
    input  wire logic        sign_i,
    input  wire logic        over_i,
    input  wire logic [19:0] digits_i,
    input  wire logic        rfd_i,
    input  wire logic        dac_i,
    output logic      [7:0]  data_o,
    output logic             dav_o,
    output logic             eoi_o,
    output logic             busy_o
);
    msh_tx_st_t  st_r;
    logic [2:0]  idx_r;
    logic [21:0] word_r;

    // Sign first, then overrange digit, then digits from the most significant
    function automatic logic [7:0] char_at(input logic [2:0] i, input logic [21:0] w);
        logic [3:0] d;
        d = 4'h0;
        if (i == 3'h0) begin
            char_at = w[21] ? `MSH_ASC_MINUS : `MSH_ASC_PLUS;
        end else begin
            if (i == 3'h1) d = {3'h0, w[20]};
            else d = w[4*(6-i) +: 4];
            char_at = `MSH_ASC_ZERO | {4'h0, d};
        end
    endfunction : char_at

    assign busy_o = (st_r != TX_IDLE);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_r   <= TX_IDLE;
            idx_r  <= 3'h0;
            word_r <= 22'h0;
            data_o <= `MSH_BUS_IDLE;
            dav_o  <= 1'b0;
            eoi_o  <= 1'b0;
        end else begin
            case (st_r)
                TX_IDLE: if (start_i) begin
                    word_r <= {sign_i, over_i, digits_i};
                    idx_r  <= 3'h0;
                    st_r   <= TX_WAIT;
                end
                TX_WAIT: if (rfd_i && !dac_i) begin
                    data_o <= char_at(idx_r, word_r);
                    eoi_o  <= (idx_r == `MSH_NCHAR - 3'h1);
                    dav_o  <= 1'b1;
                    st_r   <= TX_DAV;
                end
                TX_DAV: if (dac_i) begin
                    dav_o <= 1'b0;
                    st_r  <= TX_REL;
                end
                TX_REL: if (!dac_i) begin
                    eoi_o <= 1'b0;
                    if (idx_r == `MSH_NCHAR - 3'h1) begin
                        st_r <= TX_IDLE;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                        st_r  <= TX_WAIT;
                    end
                end
                default: st_r <= TX_IDLE;
            endcase
        end
    end
endmodule : msh_ascii_tx

// *** core/msh_device.sv ***
// Meter end of the system handshake port: triggering, programming,
// sample-and-hold sequencing, parallel BCD reading and serial talker.
// Assumes the converter answers adc_start_o with a one-cycle adc_done_i.
//
// Functional notes
// - Acknowledge rises on request, falls when ready
// - Acknowledge high over the settling (delay mode) and the digitizing
// - Controller waits for reading before next request
// - Hold-off suppresses internal trigger until released
// - Controller sets program lines, then strobes
// - Program acknowledge after settings are latched
// - Controller triggers only after programming acknowledged
// - Sequence launch only after program acknowledge
// - BCD 8-4-2-1 digits plus overrange line
// - Range on three lines weighted 4-2-1
// - Track mode follows the input continuously
// - Hold frozen for whole digitizing period
// - Delay mode inserts settling before hold
// - Serial: answer own address, 8+7 lines
// - Serial reading: sign first, then MSD down
// - Release hold to tracking after digitizing
`timescale 1ns/1ps
`include "msh_map.svh"
module msh_device
    import msh_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    msh_if.dev               bus,
    input  wire logic [4:0]  my_addr_i,
    input  wire logic        delay_mode_i,
    output logic             adc_start_o,
    input  wire logic        adc_done_i,
    input  wire logic [19:0] adc_digits_i,
    input  wire logic        adc_over_i,
    input  wire logic        adc_pol_i,
    input  wire logic        adc_input_a_i,
    output logic             sh_hold_o,
    output logic      [2:0]  cfg_range_o,
    output logic      [3:0]  cfg_func_o,
    output logic             cfg_auto_o,
    output logic             seq_start_o
);
    msh_dev_st_t st_r;
    logic [11:0] tick_cnt_r;
    logic [11:0] settle_cnt_r;
    logic        trig_q_r;
    logic        strobe_q_r;
    logic        seq_q_r;
    logic        atn_q_r;
    logic        prog_pend_r;
    logic        new_rd_r;
    logic        talker_r;
    logic [7:0]  addr_r;
    logic        int_tick;
    logic        seq_go;
    logic        go;
    logic        tx_start;
    logic        tx_busy;
    logic        tx_dav;
    logic        tx_eoi;
    logic [7:0]  tx_data;

    // Edge detectors for the controller lines
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            trig_q_r   <= 1'b0;
            strobe_q_r <= 1'b0;
            seq_q_r    <= 1'b0;
            atn_q_r    <= 1'b0;
        end else begin
            trig_q_r   <= bus.trig;
            strobe_q_r <= bus.program_strobe;
            seq_q_r    <= bus.seq_launch;
            atn_q_r    <= bus.atn;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i || !bus.hold_off_n || int_tick) tick_cnt_r <= 12'h0;
        else tick_cnt_r <= tick_cnt_r + 12'h1;
    end
    assign int_tick = bus.hold_off_n && (tick_cnt_r == 12'(`MSH_TRIG_CYC - 1));

    assign seq_go = bus.seq_launch && !seq_q_r && bus.prog_ack;
    assign go = (st_r == DV_IDLE) && !prog_pend_r
              && ((bus.trig && !trig_q_r) || int_tick || seq_go);

    always_ff @(posedge clock_i) begin
        if (reset_i) seq_start_o <= 1'b0;
        else seq_start_o <= go && seq_go;
    end

    // Reading sequence: settle (optional), hold and convert, release
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_r         <= DV_IDLE;
            settle_cnt_r <= 12'h0;
            adc_start_o  <= 1'b0;
        end else begin
            adc_start_o <= 1'b0;
            case (st_r)
                DV_IDLE: if (go) begin
                    settle_cnt_r <= 12'h0;
                    if (delay_mode_i) begin
                        st_r <= DV_SETTLE;
                    end else begin
                        st_r        <= DV_CONV;
                        adc_start_o <= 1'b1;
                    end
                end
                DV_SETTLE: begin
                    settle_cnt_r <= settle_cnt_r + 12'h1;
                    if (settle_cnt_r == 12'(`MSH_SETTLE_CYC - 1)) begin
                        st_r        <= DV_CONV;
                        adc_start_o <= 1'b1;
                    end
                end
                DV_CONV: if (adc_done_i) st_r <= DV_IDLE;
                default: st_r <= DV_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) sh_hold_o <= 1'b0;
        else if (st_r == DV_IDLE || st_r == DV_SETTLE)
            sh_hold_o <= (st_r == DV_IDLE && go && !delay_mode_i)
                      || (st_r == DV_SETTLE && settle_cnt_r == 12'(`MSH_SETTLE_CYC - 1));
        else if (adc_done_i) sh_hold_o <= 1'b0;
    end

    // rise on accept, fall with data
    always_ff @(posedge clock_i) begin
        if (reset_i) bus.flag <= 1'b0;
        else if (go) bus.flag <= 1'b1;
        else if (st_r == DV_CONV && adc_done_i) bus.flag <= 1'b0;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus.rd_digits <= 20'h0;
            bus.rd_over   <= 1'b0;
            bus.rd_pol    <= 1'b0;
            bus.rd_range  <= `MSH_RANGE_RST;
            bus.input_a   <= 1'b0;
        end else if (st_r == DV_CONV && adc_done_i) begin
            bus.rd_digits <= adc_digits_i;
            bus.rd_over   <= adc_over_i;
            bus.rd_pol    <= adc_pol_i;
            bus.rd_range  <= cfg_range_o;
            bus.input_a   <= adc_input_a_i;
        end
    end

    // Strobe during a reading is held pending until the reading ends
    always_ff @(posedge clock_i) begin
        if (reset_i) prog_pend_r <= 1'b0;
        else if (bus.program_strobe && !strobe_q_r) prog_pend_r <= 1'b1;
        else if (st_r == DV_IDLE) prog_pend_r <= 1'b0;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg_range_o <= `MSH_RANGE_RST;
            cfg_func_o  <= `MSH_FUNC_RST;
            cfg_auto_o  <= 1'b0;
        end else if (prog_pend_r && st_r == DV_IDLE) begin
            cfg_range_o <= bus.prog_range;
            cfg_func_o  <= bus.prog_func;
            cfg_auto_o  <= bus.auto_scale_select;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) bus.prog_ack <= 1'b0;
        else if (bus.program_strobe && !strobe_q_r) bus.prog_ack <= 1'b0;
        else if (prog_pend_r && st_r == DV_IDLE) bus.prog_ack <= 1'b1;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            addr_r   <= `MSH_BUS_IDLE;
            talker_r <= 1'b0;
        end else begin
            if (bus.atn) addr_r <= bus.dio;
            if (atn_q_r && !bus.atn) begin
                if (addr_r == (`MSH_TALK_BASE | {3'h0, my_addr_i})) talker_r <= 1'b1;
                else if (addr_r == `MSH_UNTALK || addr_r[7:5] == 3'(`MSH_TALK_BASE >> 5))
                    talker_r <= 1'b0;
            end
        end
    end

    // A completed reading waits for the talker; a new one wins over the send
    always_ff @(posedge clock_i) begin
        if (reset_i) new_rd_r <= 1'b0;
        else if (st_r == DV_CONV && adc_done_i) new_rd_r <= 1'b1;
        else if (tx_start) new_rd_r <= 1'b0;
    end
    assign tx_start = talker_r && !bus.atn && bus.ren && new_rd_r && !tx_busy;

    msh_ascii_tx u_tx (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .start_i  (tx_start),
        .sign_i   (bus.rd_pol),
        .over_i   (bus.rd_over),
        .digits_i (bus.rd_digits),
        .rfd_i    (bus.rfd),
        .dac_i    (bus.dac),
        .data_o   (tx_data),
        .dav_o    (tx_dav),
        .eoi_o    (tx_eoi),
        .busy_o   (tx_busy)
    );

    assign bus.dio_d    = tx_data;
    assign bus.dio_d_oe = tx_busy && talker_r && !bus.atn;
    assign bus.dav      = tx_dav;
    assign bus.eoi      = tx_eoi;
    always_ff @(posedge clock_i) begin
        if (reset_i) bus.srq <= 1'b0;
        else bus.srq <= new_rd_r && !talker_r;
    end
endmodule : msh_device

// *** core/msh_host.sv ***
// Controller end of the system handshake port: programs the meter,
// requests readings, launches sequences and listens on the serial lines.
// Assumes one command at a time from the user side, taken while busy_o is low.
`timescale 1ns/1ps
`include "msh_map.svh"
module msh_host
    import msh_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    msh_if.host              bus,
    input  wire logic        prog_req_i,
    input  wire logic [2:0]  range_i,
    input  wire logic [3:0]  func_i,
    input  wire logic        auto_i,
    input  wire logic        meas_req_i,
    input  wire logic        seq_req_i,
    input  wire logic        hold_off_i,
    input  wire logic        talk_req_i,
    input  wire logic [4:0]  talk_addr_i,
    output logic             busy_o,
    output logic             prog_done_o,
    output logic             rd_valid_o,
    output logic      [19:0] rd_digits_o,
    output logic             rd_over_o,
    output logic             rd_pol_o,
    output logic      [2:0]  rd_range_o,
    output logic             rd_input_a_o,
    output logic      [7:0]  char_o,
    output logic             char_valid_o,
    output logic             char_last_o
);
    msh_host_st_t st_r;
    logic [2:0]   cnt_r;

    assign busy_o = (st_r != H_IDLE);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_r                  <= H_IDLE;
            cnt_r                 <= 3'h0;
            prog_done_o           <= 1'b0;
            rd_valid_o            <= 1'b0;
            bus.trig              <= 1'b0;
            bus.seq_launch        <= 1'b0;
            bus.program_strobe    <= 1'b0;
            bus.prog_range        <= `MSH_RANGE_RST;
            bus.prog_func         <= `MSH_FUNC_RST;
            bus.auto_scale_select <= 1'b0;
            bus.atn               <= 1'b0;
            bus.dio_h             <= `MSH_BUS_IDLE;
            bus.dio_h_oe          <= 1'b0;
        end else begin
            rd_valid_o     <= 1'b0;
            bus.trig       <= 1'b0;
            bus.seq_launch <= 1'b0;
            cnt_r          <= cnt_r + 3'h1;
            case (st_r)
                H_IDLE: begin
                    cnt_r <= 3'h0;
                    if (prog_req_i) begin
                        bus.prog_range        <= range_i;
                        bus.prog_func         <= func_i;
                        bus.auto_scale_select <= auto_i;
                        prog_done_o           <= 1'b0;
                        st_r                  <= H_PSET;
                    end else if (meas_req_i && prog_done_o && !bus.flag) begin
                        bus.trig <= 1'b1;
                        st_r     <= H_WHI;
                    end else if (seq_req_i && prog_done_o && !bus.flag) begin
                        bus.seq_launch <= 1'b1;
                        st_r           <= H_WHI;
                    end else if (talk_req_i) begin
                        bus.atn      <= 1'b1;
                        bus.dio_h    <= `MSH_TALK_BASE | {3'h0, talk_addr_i};
                        bus.dio_h_oe <= 1'b1;
                        st_r         <= H_ATN;
                    end
                end
                H_PSET: begin
                    bus.program_strobe <= 1'b1;
                    cnt_r              <= 3'h0;
                    st_r               <= H_PSTB;
                end
                H_PSTB: if (cnt_r == 3'(`MSH_STROBE_CYC - 1)) begin
                    bus.program_strobe <= 1'b0;
                    st_r               <= H_PACK;
                end
                H_PACK: if (bus.prog_ack) begin
                    prog_done_o <= 1'b1;
                    st_r        <= H_IDLE;
                end
                H_WHI: if (bus.flag) st_r <= H_WLO;
                H_WLO: if (!bus.flag) begin
                    rd_valid_o    <= 1'b1;
                    rd_digits_o   <= bus.rd_digits;
                    rd_over_o     <= bus.rd_over;
                    rd_pol_o      <= bus.rd_pol;
                    rd_range_o    <= bus.rd_range;
                    rd_input_a_o <= bus.input_a;
                    st_r          <= H_IDLE;
                end
                H_ATN: if (cnt_r == 3'(`MSH_ATN_CYC - 1)) begin
                    bus.atn      <= 1'b0;
                    bus.dio_h_oe <= 1'b0;
                    st_r         <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus.hold_off_n <= 1'b0;
            bus.ren        <= 1'b0;
        end else begin
            bus.hold_off_n <= !hold_off_i;
            bus.ren        <= 1'b1;
        end
    end

    // Serial listener: take byte on dav, accept, then ready again
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus.rfd      <= 1'b1;
            bus.dac      <= 1'b0;
            char_o       <= 8'h00;
            char_valid_o <= 1'b0;
            char_last_o  <= 1'b0;
        end else begin
            char_valid_o <= 1'b0;
            if (bus.dav && !bus.dac && !bus.atn) begin
                char_o       <= bus.dio;
                char_last_o  <= bus.eoi;
                char_valid_o <= 1'b1;
                bus.dac      <= 1'b1;
                bus.rfd      <= 1'b0;
            end else if (!bus.dav && bus.dac) begin
                bus.dac <= 1'b0;
                bus.rfd <= 1'b1;
            end
        end
    end
endmodule : msh_host

// *** tb/msh_chk.sv ***
// Checker of the handshake lines between the meter and its controller.
// Assumes one clock; signals taken from the joining interface by name.
`timescale 1ns/1ps
module msh_chk (
    input logic        clock_i,
    input logic        reset_i,
    input logic        trig,
    input logic        hold_off_n,
    input logic        flag,
    input logic        program_strobe,
    input logic        prog_ack,
    input logic        seq_launch,
    input logic [19:0] rd_digits,
    input logic        atn,
    input logic        dav,
    input logic        eoi,
    input logic        dac
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_flag_up;
        $rose(trig) && !flag && prog_ack |=> flag;
    endproperty
    a_flag_up: assert property (p_flag_up) else $error("flag missed trigger");
    property p_data_at_fall;
        $changed(rd_digits) |-> $fell(flag);
    endproperty
    a_data_at_fall: assert property (p_data_at_fall) else $error("data moved off fall");
    property p_hold_off;
        !hold_off_n && !trig && !seq_launch && !flag |=> !flag;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("reading while held off");
    property p_ack_clr;
        $rose(program_strobe) |=> !prog_ack;
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack not cleared");
    property p_ack_set;
        $rose(program_strobe) && !flag |-> ##2 prog_ack;
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("ack late");
    property p_ack_keep;
        prog_ack && !$rose(program_strobe) |=> prog_ack;
    endproperty
    a_ack_keep: assert property (p_ack_keep) else $error("ack dropped");
    property p_seq;
        $rose(seq_launch) && prog_ack && !flag |=> flag;
    endproperty
    a_seq: assert property (p_seq) else $error("launch ignored");
    property p_talk_atn;
        dav |-> !atn;
    endproperty
    a_talk_atn: assert property (p_talk_atn) else $error("talk during address");
    property p_dav_drop;
        dav && dac |=> !dav;
    endproperty
    a_dav_drop: assert property (p_dav_drop) else $error("dav held after dac");
    c_read: cover property ($fell(flag));
    c_prog: cover property ($rose(prog_ack));
    c_last: cover property (dav && eoi);
endmodule : msh_chk

// *** tb/test_meter_system_handshake_port.sv ***
// Testbench joining both ends; checks user-side results.
// Assumes a converter stand-in answering 20 cycles after start.
`timescale 1ns/1ps
`include "msh_map.svh"
module test_meter_system_handshake_port;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [3:0]  req     = 4'h0;
    logic        hold_off = 1'b1;
    logic        ovl     = 1'b0;
    logic        dly     = 1'b0;
    logic        adc_done = 1'b0;
    logic        adc_pol = 1'b0;
    logic        ovr     = 1'b1;
    logic [19:0] adc_dig = 20'h90817;
    logic [2:0]  rng     = 3'h0;
    logic [3:0]  fn      = 4'h0;
    logic        aut     = 1'b0;
    logic        adc_start, seq_start, sh_hold, rd_valid, prog_done, busy, c_val, c_last;
    logic        rd_over, rd_pol, cfg_auto, rd_ovl;
    logic [19:0] rd_dig;
    logic [2:0]  rd_rng, cfg_rng;
    logic [3:0]  cfg_fn;
    logic [7:0]  c_dat;
    logic [7:0]  q[$];
    int          adc_cnt = 0, fcnt = 0, hcnt = 0, scnt = 0, cyc = 0;
    int          mismatches = 0, n_checks = 0;
    int          f0, h0;
    msh_if ifc ();
    msh_device i_msh_device (.clock_i(clock_i), .reset_i(reset_i), .bus(ifc), .my_addr_i(5'h03),
        .delay_mode_i(dly), .adc_start_o(adc_start), .adc_done_i(adc_done),
        .adc_digits_i(adc_dig), .adc_over_i(ovr), .adc_pol_i(adc_pol), .adc_input_a_i(ovl),
        .sh_hold_o(sh_hold), .cfg_range_o(cfg_rng), .cfg_func_o(cfg_fn), .cfg_auto_o(cfg_auto),
        .seq_start_o(seq_start));
    msh_host i_msh_host (.clock_i(clock_i), .reset_i(reset_i), .bus(ifc), .prog_req_i(req[0]),
        .range_i(rng), .func_i(fn), .auto_i(aut), .meas_req_i(req[1]), .seq_req_i(req[2]),
        .hold_off_i(hold_off), .talk_req_i(req[3]), .talk_addr_i(5'h03), .busy_o(busy),
        .prog_done_o(prog_done), .rd_valid_o(rd_valid), .rd_digits_o(rd_dig),
        .rd_over_o(rd_over), .rd_pol_o(rd_pol), .rd_range_o(rd_rng), .rd_input_a_o(rd_ovl),
        .char_o(c_dat), .char_valid_o(c_val), .char_last_o(c_last));
    msh_chk i_msh_chk (.clock_i(clock_i), .reset_i(reset_i), .trig(ifc.trig),
        .hold_off_n(ifc.hold_off_n), .flag(ifc.flag), .program_strobe(ifc.program_strobe),
        .prog_ack(ifc.prog_ack), .seq_launch(ifc.seq_launch), .rd_digits(ifc.rd_digits),
        .atn(ifc.atn), .dav(ifc.dav), .eoi(ifc.eoi), .dac(ifc.dac));
    always #4 clock_i = ~clock_i;
    // Converter stand-in and event counters
    always @(posedge clock_i) begin
        adc_done <= (adc_cnt == 1);
        adc_cnt <= adc_start ? 20 : (adc_cnt > 0 ? adc_cnt - 1 : 0);
        fcnt <= fcnt + int'(ifc.flag);
        hcnt <= hcnt + int'(sh_hold);
        scnt <= scnt + int'(seq_start);
        cyc <= cyc + 1;
        if (c_val)
            q.push_back(c_dat);
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task wrap_up;
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    function automatic logic sel(input int w);
        case (w)
            0: return prog_done;
            1: return rd_valid;
            2: return c_val && c_last;
            3: return ifc.flag;
            default: return !busy;
        endcase
    endfunction : sel
    task wt(input int w);
        int n;
        for (n = 0; n < 4000 && sel(w) !== 1'b1; n++)
            @(posedge clock_i);
        if (n == 4000) begin
            mismatches++;
            wrap_up();
        end
    endtask : wt
    task go(input int k);
        wt(4);
        @(posedge clock_i);
        req[k] <= 1'b1;
        @(posedge clock_i);
        req[k] <= 1'b0;
    endtask : go
    initial begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        rng <= 3'h5;
        fn <= 4'h9;
        aut <= 1'b1;
        go(0);
        wt(0);
        chk("cfg_range", cfg_rng, 5);
        chk("cfg_func", cfg_fn, 9);
        chk("cfg_auto", cfg_auto, 1);
        chk("prog_ack", ifc.prog_ack, 1);
        f0 = fcnt;
        h0 = hcnt;
        go(1);
        wt(1);
        chk("rd_digits", rd_dig, 20'h90817);
        chk("rd_over", rd_over, 1);
        chk("rd_input_a", rd_ovl, 0);
        chk("rd_range", rd_rng, 5);
        chk("hold_span", hcnt - h0, fcnt - f0);
        chk("hold_free", sh_hold, 0);
        dly <= 1'b1;
        adc_pol <= 1'b1;
        ovr <= 1'b0;
        ovl <= 1'b1;
        adc_dig <= 20'h12345;
        f0 = fcnt;
        h0 = hcnt;
        go(1);
        wt(1);
        chk("settle", fcnt - f0 - (hcnt - h0), `MSH_SETTLE_CYC);
        chk("rd_pol", rd_pol, 1);
        chk("rd_input_a_set", rd_ovl, 1);
        dly <= 1'b0;
        f0 = scnt;
        go(2);
        wt(1);
        chk("seq_start", scnt - f0, 1);
        chk("srq", ifc.srq, 1);
        q.delete();
        go(3);
        wt(2);
        @(posedge clock_i);
        chk("n_chars", q.size(), 7);
        chk("sign", q[0], 8'h2D);
        chk("over", q[1], 8'h30);
        for (int i = 0; i < 5; i++)
            chk("digit", q[i+2], 8'h30 + adc_dig[19-4*i -: 4]);
        chk("srq_clear", ifc.srq, 0);
        f0 = fcnt;
        repeat (2600) @(posedge clock_i);
        chk("held_off", fcnt - f0, 0);
        f0 = cyc;
        hold_off <= 1'b0;
        wt(3);
        chk("tick_time", (cyc - f0) inside {[2500:2506]}, 1);
        wrap_up();
    end
endmodule : test_meter_system_handshake_port
